// >>> rtl/anfc_pkg.sv
package anfc_pkg;
    // ********************************************************
    // Register map of the plain register port
    // ********************************************************
    localparam logic [3:0] ANFC_MODE_OFS = 4'h0;
    localparam logic [3:0] ANFC_F3_OFS = 4'h1;
    localparam logic [3:0] ANFC_W3_OFS = 4'h2;
    localparam logic [3:0] ANFC_D3_OFS = 4'h3;
    localparam logic [3:0] ANFC_F4_OFS = 4'h4;
    localparam logic [3:0] ANFC_W4_OFS = 4'h5;
    localparam logic [3:0] ANFC_D4_OFS = 4'h6;
    localparam logic [3:0] ANFC_MEAS_OFS = 4'h7;
    localparam logic [3:0] ANFC_STAT_OFS = 4'h8;
    // ********************************************************
    // Field layout and reset values
    // ********************************************************
    localparam int ANFC_FW = 16;
    localparam int ANFC_SW = 8;
    localparam logic [15:0] ANFC_FREQ_OFF = 16'h1388;
    localparam logic [2:0] ANFC_MODE_RST = 3'h0;
    localparam logic [2:0] ANFC_MODE_MAX = 3'h4;
    localparam logic [7:0] ANFC_SEL_RST = 8'h00;
    // Status bits
    localparam int ANFC_ST_ADAPT = 0;
    localparam int ANFC_ST_NVBUSY = 1;
    localparam int ANFC_ST_LOADED = 2;
    localparam int ANFC_ST_BADMODE = 3;
    // ********************************************************
    // Timing
    // ********************************************************
    localparam longint ANFC_CLK_HZ = 64'd25000000;
    localparam longint ANFC_SAVE_MIN = 64'd30;
    localparam longint ANFC_SAVE_CYC = ANFC_SAVE_MIN * 64'd60 * ANFC_CLK_HZ;
    typedef enum logic [2:0] {
        ANFC_OFF, ANFC_ONE, ANFC_TWO, ANFC_MEAS, ANFC_CLR
    } anfc_mode_t;
endpackage : anfc_pkg

// >>> rtl/anfc_notch_set.sv
`timescale 1ns/10ps
// ********************************************************
// One notch parameter set: frequency, width, depth
// ********************************************************
module anfc_notch_set
    import anfc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic clr_i,
    input wire logic ld_i,
    input wire logic [15:0] ld_freq_i,
    input wire logic [7:0] ld_width_i,
    input wire logic [7:0] ld_depth_i,
    input wire logic adapt_i,
    input wire logic found_i,
    input wire logic [15:0] est_freq_i,
    input wire logic [7:0] est_width_i,
    input wire logic [7:0] est_depth_i,
    input wire logic [1:0] sw_wr_i,
    input wire logic [15:0] sw_data_i,
    output logic [15:0] freq_o,
    output logic [7:0] width_o,
    output logic [7:0] depth_o,
    output logic active_o
);
    // Frequency: clear beats load beats adaptation beats software
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            freq_o <= ANFC_FREQ_OFF;
        end else if (clr_i) begin
            freq_o <= ANFC_FREQ_OFF;
        end else if (ld_i) begin
            freq_o <= ld_freq_i;
        end else if (adapt_i) begin
            freq_o <= found_i ? est_freq_i : ANFC_FREQ_OFF;
        end else if (sw_wr_i == 2'h1) begin
            freq_o <= sw_data_i;
        end
    end

    // Width and depth follow the same priority
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            width_o <= ANFC_SEL_RST;
            depth_o <= ANFC_SEL_RST;
        end else if (clr_i) begin
            width_o <= ANFC_SEL_RST;
            depth_o <= ANFC_SEL_RST;
        end else if (ld_i) begin
            width_o <= ld_width_i;
            depth_o <= ld_depth_i;
        end else if (adapt_i) begin
            width_o <= est_width_i;
            depth_o <= est_depth_i;
        end else begin
            if (sw_wr_i == 2'h2) begin
                width_o <= sw_data_i[7:0];
            end
            if (sw_wr_i == 2'h3) begin
                depth_o <= sw_data_i[7:0];
            end
        end
    end

    // 5000 means the notch is switched off
    assign active_o = (freq_o != ANFC_FREQ_OFF);
endmodule : anfc_notch_set

// >>> rtl/anfc_save_timer.sv
`timescale 1ns/10ps
// ********************************************************
// Periodic save tick
// ********************************************************
module anfc_save_timer #(
    parameter longint PERIOD = anfc_pkg::ANFC_SAVE_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    output logic tick_o
);
    logic [35:0] cnt;

    // Free-running counter, one-cycle tick at wrap
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt <= 36'h0;
            tick_o <= 1'b0;
        end else if (cnt == 36'(PERIOD - 64'd1)) begin
            cnt <= 36'h0;
            tick_o <= 1'b1;
        end else begin
            cnt <= cnt + 36'h1;
            tick_o <= 1'b0;
        end
    end
endmodule : anfc_save_timer

// >>> rtl/anfc_ctrl.sv
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
// Overview of operation
// - Mode 0: no adaptation, hold notch values
// - Mode 1: adapt third notch only
// - Mode 2: adapt third and fourth notches
// - Mode 3: measure resonance, hold notch values
// - Mode 4: disable notches, clear stored results
// - Adapt only on motion, nonzero mode, resonance
// - Third frequency from estimate, else 5000
// - Fourth frequency from second estimate, else 5000
// - Third width, depth written when adapting
// - Fourth width, depth written in two-filter mode
// - Save notch sets every 30 minutes
// - Power-up: load saved notch sets
// - Frequency 5000 means notch disabled
// - No adaptation in torque control mode
// - Adapt only while servo is on
module anfc_ctrl
    import anfc_pkg::*;
#(
    parameter longint SAVE_CYC = anfc_pkg::ANFC_SAVE_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // Servo state
    input wire logic motion_cmd_i,
    input wire logic servo_on_i,
    input wire logic torque_mode_i,
    // Resonance estimator results
    input wire logic est_valid_i,
    input wire logic res_affect_i,
    input wire logic found1_i,
    input wire logic [15:0] est_freq1_i,
    input wire logic [7:0] est_width1_i,
    input wire logic [7:0] est_depth1_i,
    input wire logic found2_i,
    input wire logic [15:0] est_freq2_i,
    input wire logic [7:0] est_width2_i,
    input wire logic [7:0] est_depth2_i,
    output logic est_run_o,
    output logic est_clear_o,
    // Nonvolatile storage
    input wire logic nv_valid_i,
    input wire logic [15:0] nv_freq3_i,
    input wire logic [7:0] nv_width3_i,
    input wire logic [7:0] nv_depth3_i,
    input wire logic [15:0] nv_freq4_i,
    input wire logic [7:0] nv_width4_i,
    input wire logic [7:0] nv_depth4_i,
    input wire logic nv_ack_i,
    output logic nv_save_o,
    output logic nv_erase_o,
    output logic [15:0] nv_freq3_o,
    output logic [7:0] nv_width3_o,
    output logic [7:0] nv_depth3_o,
    output logic [15:0] nv_freq4_o,
    output logic [7:0] nv_width4_o,
    output logic [7:0] nv_depth4_o,
    // Notch filter settings to the torque path
    output logic [15:0] third_notch_frequency_o,
    output logic [7:0] third_notch_width_o,
    output logic [7:0] third_notch_depth_o,
    output logic third_notch_en_o,
    output logic [15:0] fourth_notch_frequency_o,
    output logic [7:0] fourth_notch_width_o,
    output logic [7:0] fourth_notch_depth_o,
    output logic fourth_notch_en_o
);
    import anfc_pkg::*;

    // ********************************************************
    // Mode register
    // ********************************************************
    anfc_mode_t adaptive_mode_setting;
    logic bad_mode;
    logic loaded;
    logic load_pulse;
    logic save_tick;
    logic save_pend;
    logic f3_en;
    logic f4_en;

    // New mode takes effect on the write; out-of-range is refused
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            adaptive_mode_setting <= anfc_mode_t'(ANFC_MODE_RST);
            bad_mode <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == ANFC_MODE_OFS) begin
            if (reg_wdata_i[15:0] <= 16'(ANFC_MODE_MAX)) begin
                adaptive_mode_setting <= anfc_mode_t'(reg_wdata_i[2:0]);
                bad_mode <= 1'b0;
            end else begin
                bad_mode <= 1'b1;
            end
        end
    end

    // ********************************************************
    // Adaptation qualification
    // ********************************************************
    logic adapt_ok;
    logic adapt3;
    logic adapt4;
    logic clear_now;

    // Torque mode stops it; servo-off stops it
    assign adapt_ok = motion_cmd_i && res_affect_i && servo_on_i
        && !torque_mode_i && loaded;
    assign adapt3 = adapt_ok && est_valid_i
        && (adaptive_mode_setting == ANFC_ONE || adaptive_mode_setting == ANFC_TWO);
    assign adapt4 = adapt_ok && est_valid_i && adaptive_mode_setting == ANFC_TWO;
    assign clear_now = adaptive_mode_setting == ANFC_CLR;
    // Estimator runs in any nonzero mode except clear; mode 0 and 3 hold notches
    assign est_run_o = adapt_ok && adaptive_mode_setting != ANFC_OFF
        && !clear_now;
    assign est_clear_o = clear_now;

    // ********************************************************
    // Power-up load from storage
    // ********************************************************
    // Wait for storage data before adapting, so start values are the saved ones
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            loaded <= 1'b0;
        end else if (nv_valid_i) begin
            loaded <= 1'b1;
        end
    end
    assign load_pulse = nv_valid_i && !loaded;

    // ********************************************************
    // Notch parameter sets
    // ********************************************************
    logic [1:0] sw3;
    logic [1:0] sw4;

    // Software writes are how the operator forces 5000 during recovery
    always_comb begin
        sw3 = 2'h0;
        sw4 = 2'h0;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                ANFC_F3_OFS: sw3 = 2'h1;
                ANFC_W3_OFS: sw3 = 2'h2;
                ANFC_D3_OFS: sw3 = 2'h3;
                ANFC_F4_OFS: sw4 = 2'h1;
                ANFC_W4_OFS: sw4 = 2'h2;
                ANFC_D4_OFS: sw4 = 2'h3;
                default: begin
                end
            endcase
        end
    end

    anfc_notch_set u_third (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .clr_i(clear_now),
        .ld_i(load_pulse),
        .ld_freq_i(nv_freq3_i),
        .ld_width_i(nv_width3_i),
        .ld_depth_i(nv_depth3_i),
        .adapt_i(adapt3),
        .found_i(found1_i),
        .est_freq_i(est_freq1_i),
        .est_width_i(est_width1_i),
        .est_depth_i(est_depth1_i),
        .sw_wr_i(sw3),
        .sw_data_i(reg_wdata_i),
        .freq_o(third_notch_frequency_o),
        .width_o(third_notch_width_o),
        .depth_o(third_notch_depth_o),
        .active_o(f3_en)
    );

    anfc_notch_set u_fourth (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .clr_i(clear_now),
        .ld_i(load_pulse),
        .ld_freq_i(nv_freq4_i),
        .ld_width_i(nv_width4_i),
        .ld_depth_i(nv_depth4_i),
        .adapt_i(adapt4),
        .found_i(found2_i),
        .est_freq_i(est_freq2_i),
        .est_width_i(est_width2_i),
        .est_depth_i(est_depth2_i),
        .sw_wr_i(sw4),
        .sw_data_i(reg_wdata_i),
        .freq_o(fourth_notch_frequency_o),
        .width_o(fourth_notch_width_o),
        .depth_o(fourth_notch_depth_o),
        .active_o(f4_en)
    );

    assign third_notch_en_o = f3_en;
    assign fourth_notch_en_o = f4_en;

    // ********************************************************
    // Resonance measurement result
    // ********************************************************
    logic [15:0] meas_freq;

    // Mode 3 only publishes the estimate; notches stay put
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meas_freq <= ANFC_FREQ_OFF;
        end else if (clear_now) begin
            meas_freq <= ANFC_FREQ_OFF;
        end else if (adapt_ok && est_valid_i && adaptive_mode_setting == ANFC_MEAS) begin
            meas_freq <= found1_i ? est_freq1_i : ANFC_FREQ_OFF;
        end
    end

    // ********************************************************
    // Periodic save to storage
    // ********************************************************
    anfc_save_timer #(
        .PERIOD(SAVE_CYC)
    ) u_timer (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .tick_o(save_tick)
    );

    // Request held until storage acknowledges; a tick on the ack cycle wins
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            save_pend <= 1'b0;
        end else if (save_tick) begin
            save_pend <= 1'b1;
        end else if (nv_ack_i) begin
            save_pend <= 1'b0;
        end
    end
    assign nv_save_o = save_pend;

    // Snapshot stays stable while a save is pending
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            nv_freq3_o <= ANFC_FREQ_OFF;
            nv_width3_o <= ANFC_SEL_RST;
            nv_depth3_o <= ANFC_SEL_RST;
            nv_freq4_o <= ANFC_FREQ_OFF;
            nv_width4_o <= ANFC_SEL_RST;
            nv_depth4_o <= ANFC_SEL_RST;
        end else if (save_tick) begin
            nv_freq3_o <= third_notch_frequency_o;
            nv_width3_o <= third_notch_width_o;
            nv_depth3_o <= third_notch_depth_o;
            nv_freq4_o <= fourth_notch_frequency_o;
            nv_width4_o <= fourth_notch_width_o;
            nv_depth4_o <= fourth_notch_depth_o;
        end
    end

    // Erase request for stored results during clear mode
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            nv_erase_o <= 1'b0;
        end else begin
            nv_erase_o <= clear_now;
        end
    end

    // ********************************************************
    // Read port
    // ********************************************************
    logic [15:0] next_rdata;

    // Unmapped addresses read zero
    always_comb begin
        next_rdata = 16'h0000;
        unique case (reg_addr_i)
            ANFC_MODE_OFS: next_rdata = {13'h0000, adaptive_mode_setting};
            ANFC_F3_OFS: next_rdata = third_notch_frequency_o;
            ANFC_W3_OFS: next_rdata = {8'h00, third_notch_width_o};
            ANFC_D3_OFS: next_rdata = {8'h00, third_notch_depth_o};
            ANFC_F4_OFS: next_rdata = fourth_notch_frequency_o;
            ANFC_W4_OFS: next_rdata = {8'h00, fourth_notch_width_o};
            ANFC_D4_OFS: next_rdata = {8'h00, fourth_notch_depth_o};
            ANFC_MEAS_OFS: next_rdata = meas_freq;
            ANFC_STAT_OFS: begin
                next_rdata[ANFC_ST_ADAPT] = est_run_o;
                next_rdata[ANFC_ST_NVBUSY] = save_pend;
                next_rdata[ANFC_ST_LOADED] = loaded;
                next_rdata[ANFC_ST_BADMODE] = bad_mode;
            end
            default: next_rdata = 16'h0000;
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    mode_hold_a: assert property (
        adaptive_mode_setting == ANFC_OFF && !load_pulse && !reg_wr_i
        |=> $stable(third_notch_frequency_o) && $stable(fourth_notch_frequency_o))
        else $error("notch changed in mode off");
    meas_hold_a: assert property (
        adaptive_mode_setting == ANFC_MEAS && !load_pulse && !reg_wr_i
        |=> $stable(third_notch_frequency_o) && $stable(fourth_notch_width_o))
        else $error("notch changed in measure mode");
    one_filter_a: assert property (
        adaptive_mode_setting == ANFC_ONE && !load_pulse && !reg_wr_i
        |=> $stable(fourth_notch_frequency_o))
        else $error("fourth notch moved with one filter");
    third_load_a: assert property (
        adapt3 && !clear_now && !load_pulse
        |=> third_notch_frequency_o == ($past(found1_i) ? $past(est_freq1_i) : ANFC_FREQ_OFF))
        else $error("third frequency not loaded");
    fourth_load_a: assert property (
        adapt4 && !load_pulse
        |=> fourth_notch_frequency_o == ($past(found2_i) ? $past(est_freq2_i) : ANFC_FREQ_OFF))
        else $error("fourth frequency not loaded");
    clear_mode_a: assert property (
        clear_now |=> third_notch_frequency_o == ANFC_FREQ_OFF && !f4_en && nv_erase_o)
        else $error("clear mode did not clear");
    no_torque_a: assert property (
        torque_mode_i || !servo_on_i |-> !est_run_o && !adapt3 && !adapt4)
        else $error("adapting while not allowed");
    bad_write_a: assert property (
        reg_wr_i && reg_addr_i == ANFC_MODE_OFS && reg_wdata_i > 16'h0004
        |=> $stable(adaptive_mode_setting) && bad_mode)
        else $error("illegal mode accepted");
    save_req_a: assert property (
        save_tick && !nv_ack_i |=> nv_save_o [*2])
        else $error("save request dropped");

    adapt_two_c: cover property (adapt4 ##1 adaptive_mode_setting == ANFC_TWO);
    save_done_c: cover property (nv_save_o ##1 nv_ack_i);
    clear_c: cover property (clear_now ##1 !clear_now);
endmodule : anfc_ctrl

// >>> verif/anfc_nv_model.sv
`timescale 1ns/10ps
// ****************************************
// Nonvolatile store beside the block
// ****************************************
module anfc_nv_model #(
    parameter int LOAD_DLY = 4,
    parameter int ACK_DLY = 3,
    parameter logic [63:0] INIT = 64'h0100112202003344
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic save_i,
    input wire logic erase_i,
    input wire logic [15:0] f3_i,
    input wire logic [7:0] w3_i,
    input wire logic [7:0] d3_i,
    input wire logic [15:0] f4_i,
    input wire logic [7:0] w4_i,
    input wire logic [7:0] d4_i,
    output logic valid_o,
    output logic ack_o,
    output logic [15:0] f3_o,
    output logic [7:0] w3_o,
    output logic [7:0] d3_o,
    output logic [15:0] f4_o,
    output logic [7:0] w4_o,
    output logic [7:0] d4_o
);
    // Image is not reset: it must survive a reset like real storage
    logic [63:0] mem = INIT;
    logic [3:0] up_q;
    logic [3:0] wait_q;
    // Slow write, acknowledged only after ACK_DLY cycles
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            up_q <= 4'h0;
            wait_q <= 4'h0;
            ack_o <= 1'b0;
        end else begin
            ack_o <= 1'b0;
            if (up_q != 4'(LOAD_DLY))
                up_q <= up_q + 4'h1;
            wait_q <= save_i ? wait_q + 4'h1 : 4'h0;
            if (save_i && wait_q == 4'(ACK_DLY)) begin
                ack_o <= 1'b1;
                wait_q <= 4'h0;
                mem <= {f3_i, w3_i, d3_i, f4_i, w4_i, d4_i};
            end
            if (erase_i) begin
                mem[63:48] <= 16'h1388;
                mem[31:16] <= 16'h1388;
            end
        end
    end
    // Lines show the inverse image until the store reports valid
    assign valid_o = (up_q == 4'(LOAD_DLY));
    assign {f3_o, w3_o, d3_o, f4_o, w4_o, d4_o} = valid_o ? mem : ~mem;
endmodule : anfc_nv_model

// >>> verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import anfc_pkg::*;
    localparam int SAVE_N = 20;
    logic mclk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, v;
    logic motion_cmd_i = 1'b0, servo_on_i = 1'b0, torque_mode_i = 1'b0;
    logic est_valid_i = 1'b0, res_affect_i = 1'b0, found1_i = 1'b0, found2_i = 1'b0;
    logic [15:0] est_freq1_i = 16'h0000, est_freq2_i = 16'h0000;
    logic [7:0] est_width1_i = 8'h12, est_depth1_i = 8'h34;
    logic [7:0] est_width2_i = 8'h56, est_depth2_i = 8'h78;
    logic est_run_o, est_clear_o, nv_valid_i, nv_ack_i, nv_save_o, nv_erase_o;
    logic [15:0] nv_freq3_i, nv_freq4_i, nv_freq3_o, nv_freq4_o;
    logic [7:0] nv_width3_i, nv_depth3_i, nv_width4_i, nv_depth4_i;
    logic [7:0] nv_width3_o, nv_depth3_o, nv_width4_o, nv_depth4_o;
    logic [15:0] third_notch_frequency_o, fourth_notch_frequency_o;
    logic [7:0] third_notch_width_o, third_notch_depth_o;
    logic [7:0] fourth_notch_width_o, fourth_notch_depth_o;
    logic third_notch_en_o, fourth_notch_en_o;
    int mismatches = 0;
    int n_compared = 0;
    // Short save period keeps the run small
    anfc_ctrl #(.SAVE_CYC(64'd20)) dut (.*);
    anfc_nv_model nv (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .save_i(nv_save_o),
        .erase_i(nv_erase_o), .f3_i(nv_freq3_o), .w3_i(nv_width3_o), .d3_i(nv_depth3_o),
        .f4_i(nv_freq4_o), .w4_i(nv_width4_o), .d4_i(nv_depth4_o), .valid_o(nv_valid_i),
        .ack_o(nv_ack_i), .f3_o(nv_freq3_i), .w3_o(nv_width3_i), .d3_o(nv_depth3_i),
        .f4_o(nv_freq4_i), .w4_o(nv_width4_i), .d4_o(nv_depth4_i));
    always #20 mclk_i = ~mclk_i;
    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask : rd
    task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        chk(d, exp);
    endtask : rdc
    task automatic cond(input logic m, input logic s, input logic t, input logic r);
        @(posedge mclk_i);
        motion_cmd_i <= m;
        servo_on_i <= s;
        torque_mode_i <= t;
        res_affect_i <= r;
    endtask : cond
    // One estimator result, then let the update land
    task automatic est(input logic a1, input logic [15:0] f1, input logic a2,
                       input logic [15:0] f2);
        @(posedge mclk_i);
        est_valid_i <= 1'b1;
        found1_i <= a1;
        est_freq1_i <= f1;
        found2_i <= a2;
        est_freq2_i <= f2;
        @(posedge mclk_i);
        est_valid_i <= 1'b0;
        tick(1);
    endtask : est
    // Enables follow from the frequency, 5000 meaning off
    task automatic chk6(input logic [15:0] f3, input logic [7:0] w3, input logic [7:0] d3,
                        input logic [15:0] f4, input logic [7:0] w4, input logic [7:0] d4);
        chk(third_notch_frequency_o, f3);
        chk({8'h00, third_notch_width_o}, {8'h00, w3});
        chk({8'h00, third_notch_depth_o}, {8'h00, d3});
        chk({15'h0, third_notch_en_o}, {15'h0, f3 != 16'h1388});
        chk(fourth_notch_frequency_o, f4);
        chk({8'h00, fourth_notch_width_o}, {8'h00, w4});
        chk({8'h00, fourth_notch_depth_o}, {8'h00, d4});
        chk({15'h0, fourth_notch_en_o}, {15'h0, f4 != 16'h1388});
    endtask : chk6
    task automatic wsave(input logic lv, output int n);
        n = 0;
        while (nv_save_o !== lv && n < 60) begin
            tick(1);
            n++;
        end
    endtask : wsave
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_mode1;
        wr(ANFC_MODE_OFS, 16'h0001);
        cond(1'b1, 1'b1, 1'b0, 1'b1);
        est(1'b1, 16'h0300, 1'b1, 16'h0400);
        chk6(16'h0300, 8'h12, 8'h34, 16'h0200, 8'h33, 8'h44);
        chk({15'h0, est_run_o}, 16'h0001);
        est(1'b0, 16'h0300, 1'b0, 16'h0400);
        chk(third_notch_frequency_o, 16'h1388);
        chk({15'h0, third_notch_en_o}, 16'h0000);
    endtask : t_mode1
    // Each missing condition alone must block the update
    task automatic t_gate;
        for (int i = 0; i < 4; i++) begin
            cond(i != 0, i != 2, i == 1, i != 3);
            est(1'b1, 16'h0500, 1'b1, 16'h0500);
            chk(third_notch_frequency_o, 16'h1388);
            chk({15'h0, est_run_o}, 16'h0000);
        end
        cond(1'b1, 1'b1, 1'b0, 1'b1);
    endtask : t_gate
    task automatic t_mode2;
        wr(ANFC_MODE_OFS, 16'h0002);
        est(1'b1, 16'h0600, 1'b1, 16'h0700);
        chk6(16'h0600, 8'h12, 8'h34, 16'h0700, 8'h56, 8'h78);
        est(1'b1, 16'h0600, 1'b0, 16'h0700);
        chk6(16'h0600, 8'h12, 8'h34, 16'h1388, 8'h56, 8'h78);
    endtask : t_mode2
    task automatic t_hold;
        wr(ANFC_MODE_OFS, 16'h0003);
        est(1'b1, 16'h0900, 1'b1, 16'h0A00);
        chk6(16'h0600, 8'h12, 8'h34, 16'h1388, 8'h56, 8'h78);
        rdc(ANFC_MEAS_OFS, 16'h0900);
        wr(ANFC_MODE_OFS, 16'h0000);
        est(1'b1, 16'h0900, 1'b1, 16'h0A00);
        chk6(16'h0600, 8'h12, 8'h34, 16'h1388, 8'h56, 8'h78);
    endtask : t_hold
    task automatic t_bad;
        wr(ANFC_MODE_OFS, 16'h0005);
        rdc(ANFC_MODE_OFS, 16'h0000);
        rd(ANFC_STAT_OFS, v);
        chk({15'h0, v[ANFC_ST_BADMODE]}, 16'h0001);
        chk({15'h0, v[ANFC_ST_LOADED]}, 16'h0001);
        wr(ANFC_MODE_OFS, 16'h0000);
        rd(ANFC_STAT_OFS, v);
        chk({15'h0, v[ANFC_ST_BADMODE]}, 16'h0000);
        rdc(4'hF, 16'h0000);
    endtask : t_bad
    task automatic t_recover;
        wr(ANFC_F3_OFS, 16'h1388);
        wr(ANFC_F4_OFS, 16'h1388);
        rdc(ANFC_F3_OFS, 16'h1388);
        wr(ANFC_MODE_OFS, 16'h0001);
        est(1'b1, 16'h0B00, 1'b1, 16'h0C00);
        chk6(16'h0B00, 8'h12, 8'h34, 16'h1388, 8'h56, 8'h78);
    endtask : t_recover
    // Two saves a period apart, then a reset reloads the image
    task automatic t_save;
        int n1;
        int n2;
        wsave(1'b0, n1);
        wsave(1'b1, n1);
        chk(nv_freq3_o, 16'h0B00);
        chk({nv_width3_o, nv_depth3_o}, 16'h1234);
        chk(nv_freq4_o, 16'h1388);
        chk({nv_width4_o, nv_depth4_o}, 16'h5678);
        wsave(1'b0, n1);
        wsave(1'b1, n2);
        chk(16'(n1 + n2), 16'(SAVE_N));
        wsave(1'b0, n1);
        @(posedge mclk_i);
        rst_b_i <= 1'b0;
        tick(3);
        rst_b_i <= 1'b1;
        tick(8);
        chk6(16'h0B00, 8'h12, 8'h34, 16'h1388, 8'h56, 8'h78);
        rdc(ANFC_MODE_OFS, 16'h0000);
    endtask : t_save
    task automatic t_clear;
        wr(ANFC_MODE_OFS, 16'h0004);
        tick(1);
        chk6(16'h1388, 8'h00, 8'h00, 16'h1388, 8'h00, 8'h00);
        chk({15'h0, est_clear_o}, 16'h0001);
        chk({15'h0, nv_erase_o}, 16'h0001);
        wr(ANFC_F3_OFS, 16'h0100);
        tick(1);
        chk(third_notch_frequency_o, 16'h1388);
    endtask : t_clear
    task automatic results;
        if (mismatches == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        tick(2);
        chk6(16'h1388, 8'h00, 8'h00, 16'h1388, 8'h00, 8'h00);
        @(posedge mclk_i);
        rst_b_i <= 1'b1;
        tick(8);
        chk6(16'h0100, 8'h11, 8'h22, 16'h0200, 8'h33, 8'h44);
        t_mode1();
        t_gate();
        t_mode2();
        t_hold();
        t_bad();
        t_recover();
        t_save();
        t_clear();
        results();
    end
    initial begin
        repeat (5000) @(posedge mclk_i);
        mismatches++;
        results();
    end
endmodule : tb_top
